// ==== src/mrrp_defs.vh ====
/*
 * Constants for the maintenance register read path: register-file
 * locations, shift amounts, selector codes and microcode entry codes.
 * Assumes inclusion by the design file only.
 */
`ifndef MRRP_DEFS_VH
`define MRRP_DEFS_VH

// --------------------------------------------------------------------
// Register-file locations
// --------------------------------------------------------------------
`define MRRP_RF_CAPLIST      8'h3f
`define MRRP_RF_MON_PSTATE   8'h26
`define MRRP_RF_UNTRANS_PTR  8'h21
`define MRRP_RF_SEG_LEN      8'hf0
`define MRRP_RF_SEG_ADDR     8'hef
`define MRRP_RF_PAGE_ADDR    8'h54
`define MRRP_RF_TRACE        8'h20
`define MRRP_RF_PAGE_LEN     8'h55
`define MRRP_RF_PAGE_MASK    8'h56
`define MRRP_RF_JOB_PSTATE   8'h26
`define MRRP_RF_KEYPOINT     8'h09
`define MRRP_RF_ONCOND       8'h23
`define MRRP_RF_MON_COND     8'ha5
`define MRRP_RF_USER_COND    8'ha4
`define MRRP_RF_USER_MASK    8'ha2

// --------------------------------------------------------------------
// Shift amounts
// --------------------------------------------------------------------
`define MRRP_COND_SHIFT      6'd48
`define MRRP_COND_LOW_W      48
`define MRRP_SH_SEGLEN       6'd32
`define MRRP_SH_PAGELEN      6'd16
`define MRRP_SH_PAGEMASK     6'd8
`define MRRP_SH_KEYPT        6'd48
`define MRRP_SH_ONCOND       6'd40

// --------------------------------------------------------------------
// Selector codes (low five bits of the selection index)
// --------------------------------------------------------------------
`define MRRP_SEL_MASK        8'h1f
`define MRRP_SEL_STATUS      5'h00
`define MRRP_SEL_ENVCTL      5'h01
`define MRRP_SEL_DEPENV      5'h02
`define MRRP_SEL_CSADDR      5'h03
`define MRRP_SEL_CSBRK       5'h04
`define MRRP_SEL_MONCOND     5'h05
`define MRRP_SEL_USERCOND    5'h06
`define MRRP_SEL_USERMASK    5'h07
`define MRRP_SEL_CAPLIST     5'h08
`define MRRP_SEL_MONPS       5'h09
`define MRRP_SEL_UTP         5'h0a
`define MRRP_SEL_SEGLEN      5'h0b
`define MRRP_SEL_SEGADDR     5'h0c
`define MRRP_SEL_PAGEADDR    5'h0d
`define MRRP_SEL_TRACE       5'h0e
`define MRRP_SEL_PAGELEN     5'h0f
`define MRRP_SEL_PAGEMASK    5'h10
`define MRRP_SEL_JOBPS       5'h11
`define MRRP_SEL_KEYPT       5'h12
`define MRRP_SEL_ONCOND      5'h13
`define MRRP_SEL_CTLR_FIRST  5'h14

// --------------------------------------------------------------------
// Microcode entry codes, read and write
// --------------------------------------------------------------------
`define MRRP_EC_SINGLE_RD    4'he
`define MRRP_EC_SINGLE_WR    4'hf
`define MRRP_EC_RFA_RD       4'h2
`define MRRP_EC_RFA_WR       4'h3
`define MRRP_EC_MAP_RD       4'h4
`define MRRP_EC_MAP_WR       4'h5
`define MRRP_EC_ADREG_RD     4'h6
`define MRRP_EC_ADREG_WR     4'h7
`define MRRP_EC_SCAN_RD      4'h8
`define MRRP_EC_SCAN_WR      4'h9
`define MRRP_EC_CSTORE       4'ha

`define MRRP_BYTES           4'h8

`endif

// ==== src/mrrp_top.v ====
/*
 * Maintenance register read path. Selects a source register, assembles
 * it in a 64-bit working buffer, then streams it byte by byte to the
 * maintenance access controller or writes it to the destination operand.
 * Assumes a single-ported register-file read with one-cycle latency and
 * a controller that raises ready once per byte and drops it after valid falls.
 */
// Summary of operation
// - Origin flag set for controller reads, clear for CPU copy; one shared sequence.
// - Bus-held registers take no-op entry: buffer cleared, then transferred normally.
// - Condition registers: low 48 bits from register file, high 16 from hard state.
// - Concatenated word read back, shifted right 48, rewritten before transfer.
// - CPU copy masks selector operand to choose the controller-resident register.
// - Selection table sets up streaming; byte stream routine moves bytes into buffer.
// - Origin clear: end of copy writes buffer to destination operand.
// - Controller reads address the register via selection table, shifting up to 48.
// - Register goes via A data register and B adder; buffer returned by byte path.
// - Fixed register-file locations for capability list, state, pointer, page, trace.
// - Segment table length and address come from the upper register-file area.
// - Fixed locations for page length, mask, job state, keypoint, on-condition flag.
// - Positioned registers shifted to the least significant end before streaming.
// - Microcode entry codes per access type, read/write pairs except one control-store code.
`timescale 1ns/10ps
`default_nettype none
`include "mrrp_defs.vh"

module mrrp_top (
    // Clock and reset
    input  wire        REF_CLK,
    input  wire        ARST_N,
    // Requests
    input  wire        CTLR_REQ,
    input  wire        COPY_REQ,
    input  wire [7:0]  SELECTOR_OPERAND,
    input  wire [3:0]  ACCESS_TYPE,
    input  wire        ACCESS_WRITE,
    output reg  [3:0]  ENTRY_CODE,
    output wire        BUSY,
    output reg         ORIGIN_FLAG,
    // Register file read port
    output reg  [7:0]  RF_ADDR,
    output reg         RF_RD,
    input  wire [63:0] RF_DATA,
    // Hard state and controller-resident register source
    input  wire [15:0] HARD_STATE,
    output reg  [3:0]  CTLR_REG_SEL,
    output reg         CTLR_BYTE_REQ,
    input  wire        CTLR_BYTE_VALID,
    input  wire [7:0]  CTLR_BYTE,
    // Return byte path to the controller
    output reg  [7:0]  RETURN_BYTE,
    output reg         RETURN_VALID,
    input  wire        RETURN_READY,
    // Destination operand write
    output reg  [63:0] DESTINATION_OPERAND,
    output reg         DEST_WRITE,
    output reg         DONE
);

// --------------------------------------------------------------------
// States and synchronisers
// --------------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'd0;
localparam [2:0] ST_RFRD = 3'd1;
localparam [2:0] ST_LOAD = 3'd2;
localparam [2:0] ST_COND = 3'd3;
localparam [2:0] ST_FILL = 3'd4;
localparam [2:0] ST_END  = 3'd5;
localparam [2:0] ST_SEND = 3'd6;

reg  [1:0]  ctlr_req_s;
reg  [1:0]  copy_req_s;
reg  [1:0]  byte_valid_s;
reg  [1:0]  ret_ready_s;
reg  [2:0]  state;
reg  [4:0]  sel;
reg  [63:0] working_buffer;
reg  [5:0]  pos_shift;
reg  [3:0]  byte_cnt;

// Table entry: register-file address, right shift, no-op, condition.
function [15:0] sel_rom;
    input [4:0] s;
    begin
        case (s)
            `MRRP_SEL_STATUS, `MRRP_SEL_ENVCTL, `MRRP_SEL_DEPENV,
            `MRRP_SEL_CSADDR, `MRRP_SEL_CSBRK:
                sel_rom = {8'h00, 6'd0, 2'b10};
            `MRRP_SEL_MONCOND:  sel_rom = {`MRRP_RF_MON_COND, 6'd0, 2'b01};
            `MRRP_SEL_USERCOND: sel_rom = {`MRRP_RF_USER_COND, 6'd0, 2'b01};
            `MRRP_SEL_USERMASK: sel_rom = {`MRRP_RF_USER_MASK, 6'd0, 2'b01};
            `MRRP_SEL_CAPLIST:  sel_rom = {`MRRP_RF_CAPLIST, 6'd0, 2'b00};
            `MRRP_SEL_MONPS:    sel_rom = {`MRRP_RF_MON_PSTATE, 6'd0, 2'b00};
            `MRRP_SEL_UTP:      sel_rom = {`MRRP_RF_UNTRANS_PTR, 6'd0, 2'b00};
            `MRRP_SEL_SEGLEN:   sel_rom = {`MRRP_RF_SEG_LEN, `MRRP_SH_SEGLEN, 2'b00};
            `MRRP_SEL_SEGADDR:  sel_rom = {`MRRP_RF_SEG_ADDR, 6'd0, 2'b00};
            `MRRP_SEL_PAGEADDR: sel_rom = {`MRRP_RF_PAGE_ADDR, 6'd0, 2'b00};
            `MRRP_SEL_TRACE:    sel_rom = {`MRRP_RF_TRACE, 6'd0, 2'b00};
            `MRRP_SEL_PAGELEN:  sel_rom = {`MRRP_RF_PAGE_LEN, `MRRP_SH_PAGELEN, 2'b00};
            `MRRP_SEL_PAGEMASK: sel_rom = {`MRRP_RF_PAGE_MASK, `MRRP_SH_PAGEMASK, 2'b00};
            `MRRP_SEL_JOBPS:    sel_rom = {`MRRP_RF_JOB_PSTATE, 6'd0, 2'b00};
            `MRRP_SEL_KEYPT:    sel_rom = {`MRRP_RF_KEYPOINT, `MRRP_SH_KEYPT, 2'b00};
            `MRRP_SEL_ONCOND:   sel_rom = {`MRRP_RF_ONCOND, `MRRP_SH_ONCOND, 2'b00};
            default:            sel_rom = {8'h00, 6'd0, 2'b10};
        endcase
    end
endfunction

wire [15:0] rom_word   = sel_rom(sel);
wire [7:0]  rom_addr   = rom_word[15:8];
wire [5:0]  rom_shift  = rom_word[7:2];
wire        rom_noop   = rom_word[1];
wire        rom_cond   = rom_word[0];
wire        ctlr_res   = (sel >= `MRRP_SEL_CTLR_FIRST);
wire [7:0]  sel_masked = SELECTOR_OPERAND & `MRRP_SEL_MASK;

assign BUSY = (state != ST_IDLE);

// Entry code lookup for the access type and direction.
function [3:0] entry_of;
    input [3:0] t;
    input       w;
    begin
        case (t)
            4'hf:    entry_of = w ? `MRRP_EC_SINGLE_WR : `MRRP_EC_SINGLE_RD;
            4'h1:    entry_of = w ? `MRRP_EC_RFA_WR : `MRRP_EC_RFA_RD;
            4'h2:    entry_of = w ? `MRRP_EC_MAP_WR : `MRRP_EC_MAP_RD;
            4'h3:    entry_of = w ? `MRRP_EC_ADREG_WR : `MRRP_EC_ADREG_RD;
            4'h4:    entry_of = w ? `MRRP_EC_SCAN_WR : `MRRP_EC_SCAN_RD;
            4'h5:    entry_of = `MRRP_EC_CSTORE;
            default: entry_of = 4'h0;
        endcase
    end
endfunction

// --------------------------------------------------------------------
// Sequencer
// --------------------------------------------------------------------
always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        ctlr_req_s          <= 2'b00;
        copy_req_s          <= 2'b00;
        byte_valid_s        <= 2'b00;
        ret_ready_s         <= 2'b00;
        state               <= ST_IDLE;
        sel                 <= 5'h00;
        working_buffer      <= 64'h0;
        pos_shift           <= 6'd0;
        byte_cnt            <= 4'h0;
        ENTRY_CODE          <= 4'h0;
        ORIGIN_FLAG         <= 1'b0;
        RF_ADDR             <= 8'h00;
        RF_RD               <= 1'b0;
        CTLR_REG_SEL        <= 4'h0;
        CTLR_BYTE_REQ       <= 1'b0;
        RETURN_BYTE         <= 8'h00;
        RETURN_VALID        <= 1'b0;
        DESTINATION_OPERAND <= 64'h0;
        DEST_WRITE          <= 1'b0;
        DONE                <= 1'b0;
    end else begin
        ctlr_req_s   <= {ctlr_req_s[0], CTLR_REQ};
        copy_req_s   <= {copy_req_s[0], COPY_REQ};
        byte_valid_s <= {byte_valid_s[0], CTLR_BYTE_VALID};
        ret_ready_s  <= {ret_ready_s[0], RETURN_READY};
        RF_RD        <= 1'b0;
        DEST_WRITE   <= 1'b0;
        DONE         <= 1'b0;
        case (state)
            ST_IDLE: begin
                // A controller request wins when both arrive together.
                if (ctlr_req_s[1] || copy_req_s[1]) begin
                    ORIGIN_FLAG    <= ctlr_req_s[1];
                    ENTRY_CODE     <= entry_of(ACCESS_TYPE, ACCESS_WRITE);
                    sel            <= sel_masked[4:0];
                    working_buffer <= 64'h0;
                    byte_cnt       <= 4'h0;
                    state          <= ST_RFRD;
                end
            end
            ST_RFRD: begin
                pos_shift <= rom_shift;
                if (ctlr_res && !ORIGIN_FLAG) begin
                    CTLR_REG_SEL  <= sel[3:0] - 4'h4;
                    CTLR_BYTE_REQ <= 1'b1;
                    state         <= ST_FILL;
                end else if (rom_noop || ctlr_res) begin
                    state <= ST_END;
                end else begin
                    RF_ADDR <= rom_addr;
                    RF_RD   <= 1'b1;
                    state   <= ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (!RF_RD) begin
                    if (rom_cond) begin
                        working_buffer <= {HARD_STATE,
                            RF_DATA[`MRRP_COND_LOW_W-1:0]};
                        state <= ST_COND;
                    end else begin
                        working_buffer <= RF_DATA >> pos_shift;
                        state <= ST_END;
                    end
                end
            end
            ST_COND: begin
                working_buffer <= working_buffer >> `MRRP_COND_SHIFT;
                state          <= ST_END;
            end
            ST_FILL: begin
                // Bytes arrive most significant first and shift in from the low end.
                if (byte_valid_s[1]) begin
                    working_buffer <= {working_buffer[55:0], CTLR_BYTE};
                    byte_cnt       <= byte_cnt + 4'h1;
                    CTLR_BYTE_REQ  <= 1'b0;
                    state          <= ST_SEND;
                end
            end
            ST_END: begin
                byte_cnt <= 4'h0;
                if (ORIGIN_FLAG) begin
                    state <= ST_SEND;
                end else begin
                    DESTINATION_OPERAND <= working_buffer;
                    DEST_WRITE          <= 1'b1;
                    DONE                <= 1'b1;
                    state               <= ST_IDLE;
                end
            end
            ST_SEND: begin
                if (!ORIGIN_FLAG) begin
                    // Waits for the byte strobe to fall before asking again.
                    if (!byte_valid_s[1]) begin
                        if (byte_cnt == `MRRP_BYTES) begin
                            state <= ST_END;
                        end else begin
                            CTLR_BYTE_REQ <= 1'b1;
                            state         <= ST_FILL;
                        end
                    end
                end else if (RETURN_VALID) begin
                    if (ret_ready_s[1]) begin
                        RETURN_VALID <= 1'b0;
                        if (byte_cnt == `MRRP_BYTES) begin
                            DONE  <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                end else if (!ret_ready_s[1]) begin
                    // Ready must be seen low again first, or a stale ready takes the byte.
                    RETURN_BYTE    <= working_buffer[7:0];
                    RETURN_VALID   <= 1'b1;
                    working_buffer <= working_buffer >> 8;
                    byte_cnt       <= byte_cnt + 4'h1;
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end

endmodule // mrrp_top

`default_nettype wire

// ==== tb/mrrp_chk.sv ====
/* Port checker for mrrp_top.
   Assumes a bind to mrrp_top and a single clock domain. */
`timescale 1ns/10ps
`default_nettype none
module mrrp_chk (
    // Clock, reset and status
    input wire logic       REF_CLK,
    input wire logic       ARST_N,
    input wire logic       BUSY,
    input wire logic       ORIGIN_FLAG,
    input wire logic [3:0] ENTRY_CODE,
    input wire logic       DEST_WRITE,
    input wire logic       DONE,
    // Register file and controller paths
    input wire logic [7:0] RF_ADDR,
    input wire logic       RF_RD,
    input wire logic [3:0] CTLR_REG_SEL,
    input wire logic       CTLR_BYTE_REQ,
    input wire logic [7:0] RETURN_BYTE,
    input wire logic       RETURN_VALID,
    input wire logic       RETURN_READY
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!ARST_N);
    a_rd_pulse: assert property (RF_RD |-> BUSY ##1 !RF_RD) else $error("read held");
    a_rd_where: assert property (RF_RD |-> RF_ADDR inside {8'h3f, 8'h26, 8'h21,
        8'hf0, 8'hef, 8'h54, 8'h20, 8'h55, 8'h56, 8'h09, 8'h23, 8'ha5, 8'ha4, 8'ha2})
        else $error("bad location");
    a_dw_copy: assert property (DEST_WRITE |-> DONE && !ORIGIN_FLAG) else $error("bad write");
    a_ret_origin: assert property (RETURN_VALID |-> ORIGIN_FLAG && BUSY) else $error("stray");
    a_ret_hold: assert property (RETURN_VALID && !RETURN_READY |=>
        RETURN_VALID && $stable(RETURN_BYTE)) else $error("byte dropped");
    a_fill_copy: assert property (CTLR_BYTE_REQ |-> !ORIGIN_FLAG && CTLR_REG_SEL <= 4'hb)
        else $error("bad fill");
    a_code_map: assert property (BUSY |-> !(ENTRY_CODE inside {4'h1, 4'hb, 4'hc, 4'hd}))
        else $error("bad code");
    a_busy_end: assert property ($rose(BUSY) |-> ##[1:1000] DONE) else $error("no done");
    c_copy: cover property (DEST_WRITE);
    c_stream: cover property (RETURN_VALID && RETURN_READY);
    c_fill: cover property (CTLR_BYTE_REQ ##1 !CTLR_BYTE_REQ);
endmodule // mrrp_chk
`default_nettype wire

// ==== tb/mrrp_mac_model.sv ====
/* Controller model: takes returned bytes, supplies fill bytes on request.
   Assumes the block's clock; it acts on the falling edge. */
`timescale 1ns/10ps
`default_nettype none
module mrrp_mac_model (
    // Clock and stall length
    input  wire logic        clk,
    input  wire logic [3:0]  stall,
    // Return byte path
    input  wire logic [7:0]  ret_byte,
    input  wire logic        ret_valid,
    output wire logic        ret_ready,
    output wire logic [63:0] rx_word,
    output wire logic [7:0]  rx_count,
    // Fill byte source
    input  wire logic [63:0] fill_word,
    input  wire logic        byte_req,
    output wire logic        byte_valid,
    output wire logic [7:0]  byte_out
);
    logic        rdy = 1'b0;
    logic        bvl = 1'b0;
    logic [7:0]  bout = 8'h00;
    logic [7:0]  cnt = 8'h00;
    logic [63:0] word = 64'h0;
    logic [3:0]  wait_r = 4'h0;
    logic [3:0]  wait_s = 4'h0;
    logic [2:0]  idx = 3'h0;
    assign ret_ready = rdy;
    assign rx_word = word;
    assign rx_count = cnt;
    assign byte_valid = bvl;
    assign byte_out = bout;
    // Both paths are four-phase: a strobe falls only once the other side lets go.
    always @(negedge clk) begin
        if (ret_valid && !rdy && wait_r != stall) begin
            wait_r <= wait_r + 4'h1;
        end else if (ret_valid && !rdy) begin
            word <= {ret_byte, word[63:8]};
            cnt <= cnt + 8'h01;
            rdy <= 1'b1;
            wait_r <= 4'h0;
        end else if (!ret_valid) begin
            rdy <= 1'b0;
        end
        if (byte_req && !bvl && wait_s != stall) begin
            wait_s <= wait_s + 4'h1;
        end else if (byte_req && !bvl) begin
            bout <= fill_word[8*(7-idx) +: 8];
            bvl <= 1'b1;
            idx <= idx + 3'h1;
            wait_s <= 4'h0;
        end else if (!byte_req && bvl) begin
            bvl <= 1'b0;
            bout <= ~bout;
        end
    end
endmodule // mrrp_mac_model
`default_nettype wire

// ==== tb/testbench.sv ====
/* Self-checking bench for mrrp_top with a register file and controller model.
   Assumes mrrp_top, mrrp_chk and mrrp_mac_model are compiled. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        ctlr_req = 1'b0;
    logic        copy_req = 1'b0;
    logic        acc_wr = 1'b0;
    logic        rf_hold = 1'b0;
    logic [7:0]  sel = 8'h00;
    logic [3:0]  acc_type = 4'h0;
    logic [3:0]  stall = 4'h0;
    logic [15:0] hs = 16'h0000;
    logic [63:0] rf_data = 64'h0;
    logic [63:0] fill = 64'h0;
    logic        busy, origin, rf_rd, b_req, b_vld, r_vld, r_rdy, dw, done;
    logic [3:0]  code, rsel, s_sel, s_code;
    logic [7:0]  rf_addr, b_in, r_byte, rx_cnt, s_addr, rx0;
    logic [63:0] dest, rx_word, s_dest;
    logic        s_dw, s_org;
    int          mismatches = 0;
    int          num_checks = 0;
    logic [3:0]  typ_t [6] = '{4'hf, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
    logic [3:0]  rd_t [6] = '{4'he, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha};
    logic [3:0]  wr_t [6] = '{4'hf, 4'h3, 4'h5, 4'h7, 4'h9, 4'ha};
    logic [7:0]  loc_t [12] = '{8'h3f, 8'h26, 8'h21, 8'hf0, 8'hef, 8'h54, 8'h20, 8'h55,
                                8'h56, 8'h26, 8'h09, 8'h23};
    int          shf_t [12] = '{0, 0, 0, 32, 0, 0, 0, 16, 8, 0, 48, 40};
    logic [7:0]  cnd_t [3] = '{8'ha5, 8'ha4, 8'ha2};
    mrrp_top dut_u (.REF_CLK(ref_clk), .ARST_N(arst_n), .CTLR_REQ(ctlr_req),
        .COPY_REQ(copy_req), .SELECTOR_OPERAND(sel), .ACCESS_TYPE(acc_type),
        .ACCESS_WRITE(acc_wr), .ENTRY_CODE(code), .BUSY(busy), .ORIGIN_FLAG(origin),
        .RF_ADDR(rf_addr), .RF_RD(rf_rd), .RF_DATA(rf_data), .HARD_STATE(hs),
        .CTLR_REG_SEL(rsel), .CTLR_BYTE_REQ(b_req), .CTLR_BYTE_VALID(b_vld), .CTLR_BYTE(b_in),
        .RETURN_BYTE(r_byte), .RETURN_VALID(r_vld), .RETURN_READY(r_rdy),
        .DESTINATION_OPERAND(dest), .DEST_WRITE(dw), .DONE(done));
    mrrp_mac_model mac_u (.clk(ref_clk), .stall(stall), .ret_byte(r_byte), .ret_valid(r_vld),
        .ret_ready(r_rdy), .rx_word(rx_word), .rx_count(rx_cnt), .fill_word(fill),
        .byte_req(b_req), .byte_valid(b_vld), .byte_out(b_in));
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    function automatic logic [63:0] rf_val(input logic [7:0] a);
        return {8{a}} ^ 64'hfedc_ba98_7654_3210;
    endfunction
    // Read data stays over two rising edges, then turns over so a late sample fails.
    always @(negedge ref_clk) begin
        rf_hold <= rf_rd;
        if (rf_rd === 1'b1) begin
            rf_data <= rf_val(rf_addr);
        end else if (rf_hold !== 1'b1) begin
            rf_data <= ~rf_data;
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] expected);
        num_checks++;
        if (seen !== expected) begin
            mismatches++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, expected);
        end
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic run_op(input logic ctl, input logic [7:0] s, input logic [3:0] t,
                          input logic w);
        int n;
        rx0 = rx_cnt;
        s_dw = 1'b0;
        s_sel = 4'hf;
        s_dest = 64'h0;
        @(negedge ref_clk);
        sel = s;
        acc_type = t;
        acc_wr = w;
        ctlr_req = ctl;
        copy_req = !ctl;
        for (n = 0; n < 500 && done !== 1'b1; n++) begin
            @(negedge ref_clk);
            if (busy === 1'b1) begin
                ctlr_req = 1'b0;
                copy_req = 1'b0;
            end
            if (rf_rd === 1'b1) s_addr = rf_addr;
            if (b_req === 1'b1) s_sel = rsel;
            if (dw === 1'b1) begin
                s_dw = 1'b1;
                s_dest = dest;
            end
        end
        if (n == 500) check(1'b0, 1'b1);
        s_code = code;
        s_org = origin;
    endtask
    task automatic ctlr_read(input logic [7:0] s, input logic [63:0] expected);
        run_op(1'b1, s, 4'h1, 1'b0);
        check(rx_cnt - rx0, 64'd8);
        check(rx_word, expected);
        check(s_org, 1'b1);
        check(s_dw, 1'b0);
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_codes;
        for (int i = 0; i < 12; i++) begin
            run_op(1'b0, 8'h0f, typ_t[i/2], i[0]);
            check(s_code, i[0] ? wr_t[i/2] : rd_t[i/2]);
            check(s_org, 1'b0);
            check(s_dest, rf_val(8'h55) >> 16);
        end
        run_op(1'b0, 8'h0f, 4'h0, 1'b0);
        check(s_code, 4'h0);
    endtask
    task automatic t_locs;
        for (int i = 0; i < 12; i++) begin
            run_op(1'b0, 8'h08 + i[7:0], 4'h2, 1'b1);
            check(s_addr, loc_t[i]);
            check(s_dest, rf_val(loc_t[i]) >> shf_t[i]);
            check(s_dw, 1'b1);
            check(rx_cnt - rx0, 64'd0);
        end
    endtask
    task automatic t_stream;
        stall = 4'h5;
        ctlr_read(8'h12, rf_val(8'h09) >> 48);
        check(s_addr, 8'h09);
        stall = 4'h0;
        ctlr_read(8'h08, rf_val(8'h3f));
        for (int i = 0; i < 5; i++) ctlr_read(i[7:0], 64'h0);
        ctlr_read(8'h15, 64'h0);
        for (int i = 0; i < 3; i++) begin
            hs = 16'h5a3c ^ i[15:0];
            ctlr_read(8'h05 + i[7:0], {48'h0, hs});
            check(s_addr, cnd_t[i]);
        end
    endtask
    task automatic t_fill;
        fill = 64'h0123_4567_89ab_cdef;
        run_op(1'b0, 8'h35, 4'h3, 1'b0);
        check(s_sel, 4'h1);
        check(s_dest, fill);
        stall = 4'h3;
        fill = 64'hf0e1_d2c3_b4a5_9687;
        run_op(1'b0, 8'hff, 4'h4, 1'b1);
        check(s_sel, 4'hb);
        check(s_dest, fill);
        check(s_org, 1'b0);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1'b1;
        t_codes();
        t_locs();
        t_stream();
        t_fill();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        check(1'b0, 1'b1);
        give_verdict();
    end
endmodule // testbench
bind mrrp_top mrrp_chk chk_u (.REF_CLK, .ARST_N, .BUSY, .ORIGIN_FLAG, .ENTRY_CODE,
    .DEST_WRITE, .DONE, .RF_ADDR, .RF_RD, .CTLR_REG_SEL, .CTLR_BYTE_REQ, .RETURN_BYTE,
    .RETURN_VALID, .RETURN_READY);
`default_nettype wire
